// ===== hw/msmo_top.sv
// modem state monitor and override: ahb-lite registers, rx and tx machines
// assumes modem event inputs come from logic on ref_clk, single ahb slave
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "msmo_consts.svh"
module msmo_top (
  input wire logic ref_clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // demodulation events
  input wire logic rx_on,
  input wire logic rx_pkt_detect,
  input wire logic rx_sync_done,
  input wire logic rx_sig_ok,
  input wire logic rx_est_done,
  input wire logic rx_last_symbol,
  // modulation events
  input wire logic tx_on,
  input wire logic tx_start,
  input wire logic tx_step,
  // machine states and tone
  output logic [2:0] rx_state,
  output logic [3:0] tx_state,
  output logic [9:0] tone_phase,
  output logic tone_out
);
  // reset release synchroniser
  logic rst_meta_reg; // first stage
  logic rst_n_sync; // released reset copy
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'h0;
      rst_n_sync <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_n_sync <= rst_meta_reg;
    end
  end

  // true when the latched address selects a register
  function automatic logic msmo_hit(input logic [31:0] a, input logic [31:0] off);
    msmo_hit = (a[31:2] == off[31:2]);
  endfunction

  // bus state
  logic [31:0] addr_reg; // data phase address
  logic [31:0] addr_next;
  logic rd_phase_reg; // read data phase open
  logic rd_phase_next;
  logic wr_phase_reg; // write data phase open
  logic wr_phase_next;
  logic rd_done_reg; // read word loaded
  logic rd_done_next;
  logic [31:0] hrdata_reg; // read data
  logic [31:0] hrdata_next;
  logic addr_take; // address phase accepted
  logic wr_commit; // write data present

  // register state
  logic rx_hold_reg; // receive hold bit
  logic rx_hold_next;
  logic [2:0] rx_target_reg; // recorded receive target
  logic [2:0] rx_target_next;
  logic [3:0] tx_target_reg; // recorded transmit target
  logic [3:0] tx_target_next;
  logic tx_hold_reg; // transmit hold bit
  logic tx_hold_next;
  logic tone_en_reg; // tone generator on
  logic tone_en_next;
  logic [7:0] tone_word_reg; // tone frequency word
  logic [7:0] tone_word_next;
  logic rx_hold_prev_reg; // hold one cycle back
  logic tx_hold_prev_reg;

  // machine state
  msmo_pkg::msmo_rx_state_t rx_st_reg; // demodulation state
  msmo_pkg::msmo_rx_state_t rx_st_next;
  logic [3:0] tx_st_reg; // modulation state
  logic [3:0] tx_st_next;

  // read wait only while the word is being fetched
  assign hreadyout = !(rd_phase_reg && !rd_done_reg);
  assign hresp = 1'h0;
  assign hrdata = hrdata_reg;
  assign addr_take = hsel && htrans[1] && hready;
  assign wr_commit = wr_phase_reg;

  // bus phase tracking and read data fetch
  always_comb begin
    addr_next = addr_reg;
    rd_phase_next = rd_phase_reg;
    wr_phase_next = wr_phase_reg;
    rd_done_next = rd_phase_reg && !hreadyout;
    hrdata_next = hrdata_reg;
    // close data phase when it completes
    if (hreadyout) begin
      rd_phase_next = 1'h0;
      wr_phase_next = 1'h0;
    end
    // open new data phase
    if (addr_take) begin
      addr_next = haddr;
      rd_phase_next = !hwrite;
      wr_phase_next = hwrite;
    end
    // fetch word in the wait cycle
    if (rd_phase_reg && !rd_done_reg) begin
      hrdata_next = 32'h0000_0000;
      if (msmo_hit(addr_reg, `MSMO_ADDR_STATUS)) begin
        hrdata_next[`MSMO_RX_FIELD_HI:`MSMO_RX_FIELD_LO] = rx_st_reg;
        hrdata_next[`MSMO_TX_FIELD_HI:`MSMO_TX_FIELD_LO] = tx_st_reg;
        hrdata_next[`MSMO_RX_HOLD_BIT] = rx_hold_reg;
      end else if (msmo_hit(addr_reg, `MSMO_ADDR_CTRL)) begin
        hrdata_next[`MSMO_TX_HOLD_BIT] = tx_hold_reg;
        hrdata_next[`MSMO_TONE_EN_BIT] = tone_en_reg;
      end else if (msmo_hit(addr_reg, `MSMO_ADDR_TONE)) begin
        hrdata_next[7:0] = tone_word_reg;
      end
    end
  end

  // bus registers
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      addr_reg <= 32'h0000_0000;
      rd_phase_reg <= 1'h0;
      wr_phase_reg <= 1'h0;
      rd_done_reg <= 1'h0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      addr_reg <= addr_next;
      rd_phase_reg <= rd_phase_next;
      wr_phase_reg <= wr_phase_next;
      rd_done_reg <= rd_done_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // software register writes
  always_comb begin
    rx_hold_next = rx_hold_reg;
    rx_target_next = rx_target_reg;
    tx_target_next = tx_target_reg;
    tx_hold_next = tx_hold_reg;
    tone_en_next = tone_en_reg;
    tone_word_next = tone_word_reg;
    if (wr_commit && msmo_hit(addr_reg, `MSMO_ADDR_STATUS)) begin
      rx_hold_next = hwdata[`MSMO_RX_HOLD_BIT];
      rx_target_next = hwdata[`MSMO_RX_FIELD_HI:`MSMO_RX_FIELD_LO];
      tx_target_next = hwdata[`MSMO_TX_FIELD_HI:`MSMO_TX_FIELD_LO];
    end
    if (wr_commit && msmo_hit(addr_reg, `MSMO_ADDR_CTRL)) begin
      tx_hold_next = hwdata[`MSMO_TX_HOLD_BIT];
      tone_en_next = hwdata[`MSMO_TONE_EN_BIT];
    end
    if (wr_commit && msmo_hit(addr_reg, `MSMO_ADDR_TONE)) begin
      tone_word_next = hwdata[7:0];
    end
  end

  // software registers
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rx_hold_reg <= `MSMO_RX_HOLD_RST;
      rx_target_reg <= `MSMO_RX_TARGET_RST;
      tx_target_reg <= `MSMO_TX_TARGET_RST;
      tx_hold_reg <= `MSMO_TX_HOLD_RST;
      tone_en_reg <= `MSMO_TONE_EN_RST;
      tone_word_reg <= `MSMO_TONE_WORD_RST;
      rx_hold_prev_reg <= `MSMO_RX_HOLD_RST;
      tx_hold_prev_reg <= `MSMO_TX_HOLD_RST;
    end else begin
      rx_hold_reg <= rx_hold_next;
      rx_target_reg <= rx_target_next;
      tx_target_reg <= tx_target_next;
      tx_hold_reg <= tx_hold_next;
      tone_en_reg <= tone_en_next;
      tone_word_reg <= tone_word_next;
      rx_hold_prev_reg <= rx_hold_reg;
      tx_hold_prev_reg <= tx_hold_reg;
    end
  end

  // demodulation sequencing
  always_comb begin
    rx_st_next = rx_st_reg;
    if (rx_hold_reg) begin
      rx_st_next = rx_st_reg;
    end else if (rx_hold_prev_reg) begin
      rx_st_next = msmo_pkg::msmo_rx_state_t'(rx_target_reg);
    end else if (!rx_on) begin
      rx_st_next = msmo_pkg::msmo_rx_idle;
    end else begin
      case (rx_st_reg)
        msmo_pkg::msmo_rx_idle: begin
          rx_st_next = msmo_pkg::msmo_rx_st_ready;
        end
        msmo_pkg::msmo_rx_st_ready: begin
          if (rx_pkt_detect) rx_st_next = msmo_pkg::msmo_rx_st_sync_wait;
        end
        msmo_pkg::msmo_rx_st_sync_wait: begin
          if (rx_sync_done) rx_st_next = msmo_pkg::msmo_rx_st_offset_wait;
        end
        msmo_pkg::msmo_rx_st_offset_wait: begin
          if (rx_sig_ok) rx_st_next = msmo_pkg::msmo_rx_st_offset_est;
        end
        msmo_pkg::msmo_rx_st_offset_est: begin
          if (rx_est_done) rx_st_next = msmo_pkg::msmo_rx_st_symbol_wait;
        end
        msmo_pkg::msmo_rx_st_symbol_wait: begin
          if (rx_sig_ok) rx_st_next = msmo_pkg::msmo_rx_st_symbol_detect;
        end
        msmo_pkg::msmo_rx_st_symbol_detect: begin
          if (rx_last_symbol) rx_st_next = msmo_pkg::msmo_rx_st_packet_done;
        end
        msmo_pkg::msmo_rx_st_packet_done: begin
          rx_st_next = msmo_pkg::msmo_rx_st_ready;
        end
        default: begin
          rx_st_next = msmo_pkg::msmo_rx_idle;
        end
      endcase
    end
  end

  // modulation sequencing
  always_comb begin
    tx_st_next = tx_st_reg;
    if (tx_hold_reg) begin
      tx_st_next = tx_st_reg;
    end else if (tx_hold_prev_reg) begin
      tx_st_next = tx_target_reg;
    end else if (!tx_on) begin
      tx_st_next = `MSMO_TX_IDLE;
    end else if (tx_st_reg == `MSMO_TX_IDLE) begin
      if (tx_start) tx_st_next = `MSMO_TX_WAIT1;
    end else if (tx_step) begin
      if (tx_st_reg >= `MSMO_TX_LAST) begin
        tx_st_next = `MSMO_TX_IDLE;
      end else begin
        tx_st_next = 4'(tx_st_reg + 4'h1);
      end
    end
  end

  // machine state registers
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rx_st_reg <= msmo_pkg::msmo_rx_idle;
      tx_st_reg <= `MSMO_TX_IDLE;
    end else begin
      rx_st_reg <= rx_st_next;
      tx_st_reg <= tx_st_next;
    end
  end

  assign rx_state = rx_st_reg;
  assign tx_state = tx_st_reg;

  // single-tone generator
  msmo_tone_if tone_link ();
  assign tone_link.freq_word = tone_word_reg;
  assign tone_link.enable = tone_en_reg;
  assign tone_phase = tone_link.phase;
  assign tone_out = tone_link.tone;
  msmo_tone_gen u_tone (
    .clk(ref_clk),
    .rst_n(rst_n_sync),
    .t(tone_link.gen)
  );
endmodule
`default_nettype wire

// ===== hw/msmo_consts.svh
// constants of the modem state monitor and override block
// assumes inclusion by bare name from every design file that needs them
// Notes on behaviour
// - tone frequency is clock times word over 1024
// - bit 7 holds receive machine, resets one
// - receive field write only records target state
// - receive field reads present demodulation state
// - codes 000 idle, 001 ready, 010 sync
// - codes 011 offset wait, 100 offset estimate
// - 101 symbol wait, 110 detect, 111 done
// - transmit field bits 3:0, write records target
// - transmit field reads present modulation state
`ifndef MSMO_CONSTS_SVH
`define MSMO_CONSTS_SVH
// register byte addresses
`define MSMO_ADDR_STATUS 32'h0000_2270
`define MSMO_ADDR_CTRL 32'h0000_2274
`define MSMO_ADDR_TONE 32'h0000_2278
// status register field positions
`define MSMO_RX_HOLD_BIT 7
`define MSMO_RX_FIELD_HI 6
`define MSMO_RX_FIELD_LO 4
`define MSMO_TX_FIELD_HI 3
`define MSMO_TX_FIELD_LO 0
// control register field positions
`define MSMO_TX_HOLD_BIT 0
`define MSMO_TONE_EN_BIT 1
// reset values
`define MSMO_RX_HOLD_RST 1'h1
`define MSMO_RX_TARGET_RST 3'h0
`define MSMO_TX_TARGET_RST 4'h0
`define MSMO_TX_HOLD_RST 1'h1
`define MSMO_TONE_EN_RST 1'h0
`define MSMO_TONE_WORD_RST 8'h40
// transmit codes
`define MSMO_TX_IDLE 4'h0
`define MSMO_TX_WAIT1 4'h1
`define MSMO_TX_LAST 4'h7
// tone accumulator width, 2**10 = 1024 steps per cycle
`define MSMO_TONE_ACC_W 10
`endif

// ===== hw/msmo_pkg.sv
// types of the modem state monitor and override block
// assumes no other package
package msmo_pkg;
  // receive machine codes in ascending order from 000
  typedef enum logic [2:0] {
    msmo_rx_idle,
    msmo_rx_st_ready,
    msmo_rx_st_sync_wait,
    msmo_rx_st_offset_wait,
    msmo_rx_st_offset_est,
    msmo_rx_st_symbol_wait,
    msmo_rx_st_symbol_detect,
    msmo_rx_st_packet_done
  } msmo_rx_state_t;
endpackage

// ===== hw/msmo_tone_if.sv
// link between register logic and the single-tone generator
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface msmo_tone_if;
  logic [7:0] freq_word; // tone step per clock
  logic enable; // generator running
  logic [9:0] phase; // accumulator value
  logic tone; // square tone
  modport gen (input freq_word, input enable, output phase, output tone);
  modport ctl (output freq_word, output enable, input phase, input tone);
endinterface
`default_nettype wire

// ===== hw/msmo_tone_gen.sv
// single-tone phase accumulator for rf test
// assumes dac clock equals the block clock and a synchronised reset
`timescale 1ns/1ps
`default_nettype none
`include "msmo_consts.svh"
module msmo_tone_gen (
  input wire logic clk,
  input wire logic rst_n,
  msmo_tone_if.gen t
);
  logic [`MSMO_TONE_ACC_W-1:0] phase_reg; // accumulator
  logic [`MSMO_TONE_ACC_W-1:0] phase_next;

  // next phase, wraps at 1024
  always_comb begin
    phase_next = phase_reg;
    if (t.enable) begin
      phase_next = `MSMO_TONE_ACC_W'(phase_reg + {2'h0, t.freq_word});
    end else begin
      phase_next = '0;
    end
  end

  // accumulator register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign t.phase = phase_reg;
  assign t.tone = phase_reg[`MSMO_TONE_ACC_W-1];
endmodule
`default_nettype wire

// ===== bench/msmo_top_props.sv
// checker for msmo_top: bus answer, hold and load of both machines, tone phase
// assumes binding to msmo_top with hready fed from hreadyout
`timescale 1ns/1ps
`default_nettype none
`include "msmo_consts.svh"
module msmo_top_props (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic rx_on,
  input wire logic [2:0] rx_state,
  input wire logic [3:0] tx_state,
  input wire logic [9:0] tone_phase,
  input wire logic tone_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic take; // request taken this edge
  logic dw, dr; // write or read data phase
  logic [31:0] da; // data phase address
  logic rh, th, en; // shadow holds and tone enable
  logic [2:0] rt; // shadow rx target
  logic [3:0] tt; // shadow tx target
  logic [7:0] wd; // shadow tone word
  assign take = hsel && htrans[1] && hready;
  // shadow copy of the registers, committed at the write data edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {dw, dr, da} <= '0;
      {rh, rt, tt, th, en, wd} <= {1'h1, 3'h0, 4'h0, 1'h1, 1'h0, 8'h40};
    end else begin
      if (hready) begin
        dw <= take && hwrite;
        dr <= take && !hwrite;
        da <= haddr;
      end
      if (dw && hready && da == `MSMO_ADDR_STATUS) {rh, rt, tt} <= hwdata[7:0];
      if (dw && hready && da == `MSMO_ADDR_CTRL) {en, th} <= hwdata[1:0];
      if (dw && hready && da == `MSMO_ADDR_TONE) wd <= hwdata[7:0];
    end
  end
  a_rx_hold_freeze: assert property (rh |=> $stable(rx_state))
    else $error("rx state moved while held");
  a_rx_target_load: assert property ($fell(rh) |=> rx_state == $past(rt))
    else $error("rx target not loaded");
  a_tx_hold_freeze: assert property (th |=> $stable(tx_state))
    else $error("tx state moved while held");
  a_tx_target_load: assert property ($fell(th) |=> tx_state == $past(tt))
    else $error("tx target not loaded");
  a_status_read_present: assert property (dr && hreadyout && da == `MSMO_ADDR_STATUS
    |-> hrdata == {24'h0, rh, $past(rx_state), $past(tx_state)}) else $error("status read wrong");
  a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_tone_phase_step: assert property (tone_out == tone_phase[9] &&
    tone_phase == ($past(en) ? 10'($past(tone_phase) + $past(wd)) : 10'h0)) else $error("tone step wrong");
  a_rx_off_idle: assert property (!rh && !$past(rh) && !rx_on |=> rx_state == 3'h0)
    else $error("rx not idle when off");
  c_rx_release: cover property ($fell(rh));
  c_tx_release: cover property ($fell(th));
  c_status_read: cover property (dr && hreadyout && da == `MSMO_ADDR_STATUS);
endmodule
`default_nettype wire

// ===== bench/tb_modem_state_monitor_override.sv
// testbench for msmo_top: register rows, hold release, state walk, reset values
// assumes a lone ahb-lite slave whose hreadyout feeds hready
`timescale 1ns/1ps
`default_nettype none
`include "msmo_consts.svh"
module tb_modem_state_monitor_override;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2; // whole words only
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, tone_out;
  logic [31:0] hrdata;
  logic [5:0] rxe = 6'h20; // rx_on, detect, sync, sig_ok, est, last
  logic [2:0] txe = 3'h4; // tx_on, start, step
  logic [2:0] rx_state;
  logic [3:0] tx_state;
  logic [9:0] tone_phase;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] r;
  logic [9:0] p;
  // address, write data, expected read back
  logic [95:0] rows [3] = '{{`MSMO_ADDR_TONE, 32'h5, 32'h5}, {`MSMO_ADDR_CTRL, 32'h3, 32'h3},
    {32'h227c, 32'hffff_ffff, 32'h0}};
  // rx events, tx events, expected rx and tx state; last rows step tx up to 7 and through its wrap to 0
  logic [15:0] walk [14] = '{16'h92c3, 16'h8a53, 16'h92e4, 16'h8470, 16'h8311, 16'hc2a2, 16'ha232, 16'h0202,
    16'h8293, 16'h8294, 16'h8295, 16'h8296, 16'h8297, 16'h8290};
  always #5 ref_clk = ~ref_clk;
  assign hready = hreadyout;
  msmo_top uut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_on(rxe[5]), .rx_pkt_detect(rxe[4]),
    .rx_sync_done(rxe[3]), .rx_sig_ok(rxe[2]), .rx_est_done(rxe[1]), .rx_last_symbol(rxe[0]),
    .tx_on(txe[2]), .tx_start(txe[1]), .tx_step(txe[0]), .rx_state(rx_state),
    .tx_state(tx_state), .tone_phase(tone_phase), .tone_out(tone_out));
  task automatic end_sim;
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single ahb-lite transfer, entered right after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] w, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    foreach (rows[i]) begin
      xfer(1'b1, rows[i][95:64], rows[i][63:32], r);
      xfer(1'b0, rows[i][95:64], 32'h0, r);
      chk(r, rows[i][31:0]);
    end
    // tone advances by the word each clock
    @(negedge ref_clk);
    p = tone_phase;
    repeat (4) @(negedge ref_clk);
    chk({22'h0, tone_phase}, {22'h0, p + 10'd20});
    @(posedge ref_clk);
    // targets recorded while held, loaded on release
    xfer(1'b1, `MSMO_ADDR_STATUS, 32'hb2, r);
    xfer(1'b0, `MSMO_ADDR_STATUS, 32'h0, r);
    chk(r, 32'h80);
    xfer(1'b1, `MSMO_ADDR_STATUS, 32'h32, r);
    xfer(1'b1, `MSMO_ADDR_CTRL, 32'h2, r);
    xfer(1'b0, `MSMO_ADDR_STATUS, 32'h0, r);
    chk(r, 32'h32);
    // walk both machines through their codes
    foreach (walk[i]) begin
      rxe <= walk[i][15:10];
      txe <= walk[i][9:7];
      @(posedge ref_clk);
      rxe <= 6'h20;
      txe <= 3'h4;
      @(negedge ref_clk);
      chk({25'h0, rx_state, tx_state}, {25'h0, walk[i][6:0]});
      @(posedge ref_clk);
    end
    // hold set: detect event must not move rx
    xfer(1'b1, `MSMO_ADDR_STATUS, 32'h80, r);
    rxe <= 6'h30;
    repeat (3) @(posedge ref_clk);
    rxe <= 6'h20;
    @(negedge ref_clk);
    chk({29'h0, rx_state}, 32'h1);
    // second reset mid-run, driven at a rising edge like every other input
    @(posedge ref_clk);
    rstn <= 1'b0;
    @(negedge ref_clk);
    chk({13'h0, rx_state, tx_state, tone_phase, hreadyout, hresp}, 32'h2);
    @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    xfer(1'b0, `MSMO_ADDR_STATUS, 32'h0, r);
    chk(r, 32'h80);
    xfer(1'b0, `MSMO_ADDR_CTRL, 32'h0, r);
    chk(r, 32'h1);
    xfer(1'b0, `MSMO_ADDR_TONE, 32'h0, r);
    chk(r, 32'h40);
    end_sim();
  end
endmodule
bind msmo_top msmo_top_props u_props (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .rx_on(rx_on), .rx_state(rx_state), .tx_state(tx_state),
  .tone_phase(tone_phase), .tone_out(tone_out));
`default_nettype wire
